//--- verilog/tcc_pkg.sv
/*
 * Constants and types for the timer compare-output control block.
 * Assumes an 8-bit I/O bus from the processor core and a timer datapath
 * on the same clock that holds the 16-bit registers themselves.
 */
`default_nettype none

package tcc_pkg;

    localparam logic [7:0] CTRL_A_ADDR  = 8'h72;
    localparam logic [7:0] R16_BASE     = 8'h74;
    localparam logic [7:0] R16_LAST     = 8'h7B;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] TEMP_RESET   = 8'h00;
    localparam logic [7:0] RDATA_RESET  = 8'h00;
    localparam int         FLD_A_HI     = 7;
    localparam int         FLD_A_LO     = 6;
    localparam int         FLD_B_HI     = 5;
    localparam int         FLD_B_LO     = 4;
    localparam int         WGM_HI       = 1;
    localparam int         WGM_LO       = 0;
    localparam int         NUM_CHAN     = 2;

    localparam logic [1:0] OM_OFF    = 2'b00;
    localparam logic [1:0] OM_TOGGLE = 2'b01;
    localparam logic [1:0] OM_CLEAR  = 2'b10;
    localparam logic [1:0] OM_SET    = 2'b11;

    typedef enum logic [1:0] {SEL_CNT, SEL_CMPA, SEL_CMPB, SEL_CAP}
        tcc_sel_type;
    typedef enum logic [1:0] {WM_NONPWM, WM_FAST, WM_PHASE}
        tcc_wclass_type;

    typedef struct packed {
        logic        valid;
        tcc_sel_type sel;
        logic [15:0] data;
    } tcc_wr16_type;

    typedef struct packed {
        logic        hit;
        logic        high;
        tcc_sel_type sel;
    } tcc_dec_type;

    function automatic tcc_wclass_type wave_class(input logic [3:0] wgm);
        case (wgm)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: wave_class = WM_PHASE;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: wave_class = WM_FAST;
            default: wave_class = WM_NONPWM;
        endcase
    endfunction : wave_class

    function automatic tcc_dec_type reg16_decode(input logic [7:0] addr);
        logic [7:0] off;
        off = addr - R16_BASE;
        reg16_decode.hit  = (addr >= R16_BASE) && (addr <= R16_LAST);
        reg16_decode.high = off[0];
        reg16_decode.sel  = tcc_sel_type'(off[2:1]);
    endfunction : reg16_decode

endpackage : tcc_pkg

`default_nettype wire

//--- verilog/tcc_channel.sv
/*
 * Next-state decode for one compare output.
 * Assumes single-cycle event pulses from the timer datapath.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_channel #(
    parameter bit IS_A = 1'b1
) (
    input  wire logic [1:0] mode_field,
    input  wire logic [3:0] wgm,
    input  wire logic       match,
    input  wire logic       eq_top,
    input  wire logic       at_bottom,
    input  wire logic       count_up,
    input  wire logic       oc_now,
    output var  logic       next_oc,
    output var  logic       connected
);

    tcc_pkg::tcc_wclass_type wcls;

    always_comb
    begin
        wcls      = tcc_pkg::wave_class(wgm);
        next_oc   = oc_now;
        connected = (mode_field != tcc_pkg::OM_OFF);
        case (wcls)
            tcc_pkg::WM_NONPWM:
            begin
                if (match)
                begin
                    case (mode_field)
                        tcc_pkg::OM_TOGGLE: next_oc = !oc_now;
                        tcc_pkg::OM_CLEAR:  next_oc = 1'b0;
                        tcc_pkg::OM_SET:    next_oc = 1'b1;
                        default:            next_oc = oc_now;
                    endcase
                end
            end
            default:
            begin
                // reserved 01 setting on channel b treated as disconnected
                if (mode_field == tcc_pkg::OM_TOGGLE)
                begin
                    connected = IS_A && wgm[3];
                    if (connected && match)
                        next_oc = !oc_now;
                end
                else if (mode_field[1] && wcls == tcc_pkg::WM_FAST)
                begin
                    if (at_bottom)
                        next_oc = (mode_field == tcc_pkg::OM_CLEAR);
                    else if (match && !eq_top)
                        next_oc = (mode_field == tcc_pkg::OM_SET);
                end
                else if (mode_field[1] && match)
                    next_oc = (mode_field == tcc_pkg::OM_SET) ~^ count_up;
            end
        endcase
    end

endmodule : tcc_channel

`default_nettype wire

//--- verilog/tcc_top.sv
/*
 * Compare-output control: control register A, shared high-byte temp
 * register for 16-bit access, and the two compare output pins.
 * Assumes io_* strobes and timer events come from logic on sys_clk and
 * that the timer datapath applies wr16 loads and supplies current values.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_top (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire logic [7:0]            io_addr,
    input  wire logic [7:0]            io_wdata,
    input  wire logic                  io_wr,
    input  wire logic                  io_rd,
    output var  logic [7:0]            io_rdata,
    output var  tcc_pkg::tcc_wr16_type wr16,
    input  wire logic [15:0]           counter_value,
    input  wire logic [15:0]           compare_value_a,
    input  wire logic [15:0]           compare_value_b,
    input  wire logic [15:0]           capture_value,
    input  wire logic [1:0]            waveform_mode_hi,
    input  wire logic [1:0]            cmp_match,
    input  wire logic [1:0]            cmp_eq_top,
    input  wire logic                  at_bottom,
    input  wire logic                  count_up,
    input  wire logic [1:0]            port_out,
    input  wire logic [1:0]            port_dir,
    output var  logic [1:0]            compare_out,
    output var  logic [1:0]            out_connected,
    output var  logic [1:0]            pin_out,
    output var  logic [1:0]            pin_oe
);

    logic [7:0]            timer_control_a;
    logic [7:0]            temp_hi;
    logic [7:0]            next_timer_control_a;
    logic [7:0]            next_temp_hi;
    logic [7:0]            next_io_rdata;
    tcc_pkg::tcc_wr16_type next_wr16;
    tcc_pkg::tcc_dec_type  dec;
    logic [15:0]           sel_value;
    logic [1:0]            chan_a_output_mode;
    logic [1:0]            chan_b_output_mode;
    logic [3:0]            waveform_mode;
    logic [1:0]            next_oc;
    logic [1:0]            next_conn;
    logic [1:0]            next_pin_out;

    assign chan_a_output_mode = timer_control_a[tcc_pkg::FLD_A_HI:
                                                tcc_pkg::FLD_A_LO];
    assign chan_b_output_mode = timer_control_a[tcc_pkg::FLD_B_HI:
                                                tcc_pkg::FLD_B_LO];
    assign waveform_mode = {waveform_mode_hi,
        timer_control_a[tcc_pkg::WGM_HI:tcc_pkg::WGM_LO]};

    // register access path
    always_comb
    begin
        dec                  = tcc_pkg::reg16_decode(io_addr);
        next_timer_control_a = timer_control_a;
        next_temp_hi         = temp_hi;
        next_io_rdata        = io_rdata;
        next_wr16            = '0;
        case (dec.sel)
            tcc_pkg::SEL_CNT:  sel_value = counter_value;
            tcc_pkg::SEL_CMPA: sel_value = compare_value_a;
            tcc_pkg::SEL_CMPB: sel_value = compare_value_b;
            default:           sel_value = capture_value;
        endcase
        if (io_wr)
        begin
            if (io_addr == tcc_pkg::CTRL_A_ADDR)
            begin
                next_timer_control_a = io_wdata & 8'hF3;
            end
            else if (dec.hit && dec.high)
            begin
                next_temp_hi = io_wdata;
            end
            else if (dec.hit)
            begin
                // temp left as is so it can seed further writes
                next_wr16.valid = 1'b1;
                next_wr16.sel   = dec.sel;
                next_wr16.data  = {temp_hi, io_wdata};
            end
        end
        else if (io_rd)
        begin
            next_io_rdata = tcc_pkg::RDATA_RESET;
            if (io_addr == tcc_pkg::CTRL_A_ADDR)
            begin
                next_io_rdata = timer_control_a & 8'hF3;
            end
            else if (dec.hit && !dec.high)
            begin
                next_io_rdata = sel_value[7:0];
                if (dec.sel == tcc_pkg::SEL_CNT ||
                    dec.sel == tcc_pkg::SEL_CAP)
                    next_temp_hi = sel_value[15:8];
            end
            else if (dec.hit)
            begin
                // compare high bytes bypass temp
                if (dec.sel == tcc_pkg::SEL_CNT ||
                    dec.sel == tcc_pkg::SEL_CAP)
                    next_io_rdata = temp_hi;
                else
                    next_io_rdata = sel_value[15:8];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            timer_control_a <= tcc_pkg::CTRL_A_RESET;
            temp_hi         <= tcc_pkg::TEMP_RESET;
            io_rdata        <= tcc_pkg::RDATA_RESET;
            wr16            <= '0;
        end
        else if (clk_en)
        begin
            timer_control_a <= next_timer_control_a;
            temp_hi         <= next_temp_hi;
            io_rdata        <= next_io_rdata;
            wr16            <= next_wr16;
        end
    end

    // compare output units
    genvar ch;
    generate
        for (ch = 0; ch < tcc_pkg::NUM_CHAN; ch++)
        begin : g_chan
            tcc_channel #(
                .IS_A (ch == 0)
            ) u_chan (
                .mode_field (ch == 0 ? chan_a_output_mode
                                     : chan_b_output_mode),
                .wgm        (waveform_mode),
                .match      (cmp_match[ch]),
                .eq_top     (cmp_eq_top[ch]),
                .at_bottom  (at_bottom),
                .count_up   (count_up),
                .oc_now     (compare_out[ch]),
                .next_oc    (next_oc[ch]),
                .connected  (next_conn[ch])
            );
        end
    endgenerate

    always_comb
    begin
        // pin drive also needs port_dir set, which software owns
        next_pin_out = (next_conn & next_oc)
                     | (~next_conn & port_out);
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            compare_out   <= 2'b00;
            out_connected <= 2'b00;
            pin_out       <= 2'b00;
            pin_oe        <= 2'b00;
        end
        else if (clk_en)
        begin
            compare_out   <= next_oc;
            out_connected <= next_conn;
            pin_out       <= next_pin_out;
            pin_oe        <= port_dir;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    tcc_pkg::tcc_dec_type  chk_dec;
    tcc_pkg::tcc_wclass_type chk_cls;
    assign chk_dec = tcc_pkg::reg16_decode(io_addr);
    assign chk_cls = tcc_pkg::wave_class(waveform_mode);

    a_ctrl_reserved: assert property (
        clk_en && io_rd && !io_wr && io_addr == tcc_pkg::CTRL_A_ADDR
        |=> io_rdata[3:2] == 2'b00 && timer_control_a[3:2] == 2'b00)
        else $error("reserved control bits not zero");

    a_low_write_load: assert property (
        clk_en && io_wr && chk_dec.hit && !chk_dec.high
        |=> wr16.valid && wr16.data == {$past(temp_hi), $past(io_wdata)}
            && temp_hi == $past(temp_hi))
        else $error("low byte write did not load temp and low byte");

    a_temp_shared: assert property (
        clk_en && io_wr && chk_dec.hit && chk_dec.high
        ##1 !io_wr && !io_rd
        ##1 clk_en && io_wr && chk_dec.hit && !chk_dec.high
        |=> wr16.data[15:8] == $past(io_wdata, 3))
        else $error("temp byte not shared across registers");

    a_low_read_copy: assert property (
        clk_en && io_rd && !io_wr && chk_dec.hit && !chk_dec.high
        && chk_dec.sel == tcc_pkg::SEL_CNT
        |=> temp_hi == $past(counter_value[15:8]))
        else $error("low byte read did not copy high byte");

    a_cmp_bypass: assert property (
        clk_en && io_rd && !io_wr && chk_dec.hit && chk_dec.high
        && chk_dec.sel == tcc_pkg::SEL_CMPA
        |=> io_rdata == $past(compare_value_a[15:8]) && $stable(temp_hi))
        else $error("compare read used temp byte");

    a_port_keeps_pin: assert property (
        clk_en && chan_a_output_mode == tcc_pkg::OM_OFF
        |=> !out_connected[0] && pin_out[0] == $past(port_out[0]))
        else $error("pin taken while mode field zero");

    a_nonpwm_toggle: assert property (
        clk_en && chk_cls == tcc_pkg::WM_NONPWM && cmp_match[0]
        && chan_a_output_mode == tcc_pkg::OM_TOGGLE
        |=> compare_out[0] != $past(compare_out[0]))
        else $error("non-pwm toggle missed");

    a_pwm01_off: assert property (
        clk_en && chk_cls != tcc_pkg::WM_NONPWM && !waveform_mode[3]
        && chan_b_output_mode == tcc_pkg::OM_TOGGLE
        |=> !out_connected[1] && $stable(compare_out[1]))
        else $error("pwm mode 01 connected without bit 3");

    a_fast_bottom: assert property (
        clk_en && chk_cls == tcc_pkg::WM_FAST && at_bottom
        && chan_a_output_mode == tcc_pkg::OM_CLEAR
        |=> compare_out[0])
        else $error("fast pwm bottom set missed");

    a_fast_top_skip: assert property (
        clk_en && chk_cls == tcc_pkg::WM_FAST && !at_bottom
        && cmp_match[1] && cmp_eq_top[1] && chan_b_output_mode[1]
        |=> $stable(compare_out[1]))
        else $error("match at top not ignored");

    a_phase_updown: assert property (
        clk_en && chk_cls == tcc_pkg::WM_PHASE && cmp_match[0]
        && chan_a_output_mode == tcc_pkg::OM_CLEAR
        |=> compare_out[0] == !$past(count_up))
        else $error("dual slope match action wrong");

    c_fast_cycle: cover property (
        chk_cls == tcc_pkg::WM_FAST && at_bottom ##[1:50] cmp_match[0]);
    c_two_writes: cover property (
        wr16.valid ##[1:10] wr16.valid);
    c_phase_down: cover property (
        chk_cls == tcc_pkg::WM_PHASE && cmp_match[1] && !count_up);

endmodule : tcc_top

`default_nettype wire

//--- test/tcc_timer_model.sv
/*
 * Timer datapath stand-in: holds counter, compare and capture values.
 * Assumes wr16 loads arrive as one-cycle pulses on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_timer_model (
    input  wire logic                  sys_clk,
    input  wire logic                  rstn,
    input  wire logic                  clk_en,
    input  wire tcc_pkg::tcc_wr16_type wr16,
    output var  logic [15:0]           counter_value,
    output var  logic [15:0]           compare_value_a,
    output var  logic [15:0]           compare_value_b,
    output var  logic [15:0]           capture_value
);
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            counter_value   <= 16'h0000;
            compare_value_a <= 16'h0000;
            compare_value_b <= 16'h0000;
            capture_value   <= 16'h0000;
        end
        else if (clk_en)
        begin
            // free count, so a late high read differs from the live value
            counter_value <= counter_value + 16'h0001;
            if (wr16.valid)
            begin
                case (wr16.sel)
                    tcc_pkg::SEL_CNT:  counter_value   <= wr16.data;
                    tcc_pkg::SEL_CMPA: compare_value_a <= wr16.data;
                    tcc_pkg::SEL_CMPB: compare_value_b <= wr16.data;
                    default:           capture_value   <= wr16.data;
                endcase
            end
        end
    end
endmodule : tcc_timer_model

`default_nettype wire

//--- test/test_timer16_compare_output_control.sv
/*
 * Self-checking bench for the compare-output control block.
 * Assumes the datapath stand-in and the package constants.
 */
`timescale 1ns/1ps
`default_nettype none

module test_timer16_compare_output_control;
    logic                  sys_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  clk_en = 1'b1;
    logic                  io_wr = 1'b0;
    logic                  io_rd = 1'b0;
    logic                  at_bottom = 1'b0;
    logic                  count_up = 1'b0;
    logic [7:0]            io_addr = 8'h00;
    logic [7:0]            io_wdata = 8'h00;
    logic [7:0]            io_rdata, q, hi, hc;
    logic [1:0]            wmh = 2'b00;
    logic [1:0]            cmp_match = 2'b00;
    logic [1:0]            cmp_eq_top = 2'b00;
    logic [1:0]            port_out = 2'b00;
    logic [1:0]            port_dir = 2'b00;
    logic [1:0]            compare_out, out_connected, pin_out, pin_oe;
    logic [1:0]            oe_exp, md [2];
    logic [3:0]            wg;
    logic [15:0]           cv, ca, cb, cc, v, cs, ex [4];
    tcc_pkg::tcc_wr16_type wr16, wcap;
    int                    mismatches = 0;
    int                    compares = 0;
    int                    r;
    int                    e [2] = '{-1, -1};
    int                    last [2] = '{-1, -1};
    bit                    cn [2];

    always #10 sys_clk = ~sys_clk;

    tcc_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .io_rdata(io_rdata), .wr16(wr16),
        .counter_value(cv), .compare_value_a(ca), .compare_value_b(cb),
        .capture_value(cc), .waveform_mode_hi(wmh), .cmp_match(cmp_match),
        .cmp_eq_top(cmp_eq_top), .at_bottom(at_bottom),
        .count_up(count_up), .port_out(port_out), .port_dir(port_dir),
        .compare_out(compare_out), .out_connected(out_connected),
        .pin_out(pin_out), .pin_oe(pin_oe));

    tcc_timer_model model_u (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(clk_en), .wr16(wr16), .counter_value(cv),
        .compare_value_a(ca), .compare_value_b(cb), .capture_value(cc));

    task automatic chk(input logic [15:0] s, input logic [15:0] x);
        compares++;
        if (s !== x)
        begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(negedge sys_clk);
        io_wr = w;
        io_rd = !w;
        io_addr = a;
        io_wdata = d;
        cs = cv;
        @(negedge sys_clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        q = io_rdata;
        wcap = wr16;
    endtask : bus

    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    function automatic int cls(input logic [3:0] w);
        case (w)
            4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: return 1;
            4'h5, 4'h6, 4'h7, 4'hE, 4'hF: return 2;
            default: return 0;
        endcase
    endfunction : cls

    function automatic bit conn(input int ch, input logic [1:0] m,
                                input logic [3:0] w);
        if (m == 2'b00)
            return 1'b0;
        if (cls(w) != 0 && m == 2'b01)
            return ch == 0 && w[3];
        return 1'b1;
    endfunction : conn

    function automatic int step(input int c, input int ch,
        input logic [1:0] m, input logic [3:0] w, input logic mt,
        input logic et, input logic bt, input logic up);
        if (!conn(ch, m, w))
            return -1;
        if (m == 2'b01)
            return !mt ? c : (c < 0 ? -1 : 1 - c);
        case (cls(w))
            0: return mt ? int'(m == 2'b11) : c;
            2: return bt ? int'(m == 2'b10)
                   : ((mt && !et) ? int'(m == 2'b11) : c);
            default: return mt ? int'(up == (m == 2'b11)) : c;
        endcase
    endfunction : step

    initial
    begin
        void'($urandom(32'h2f0c_bacb));
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        bus(1'b0, tcc_pkg::CTRL_A_ADDR, 8'h00);
        chk(16'(q), 16'h0000);
        bus(1'b0, 8'h75, 8'h00);
        chk(16'(q), 16'h0000);
        bus(1'b1, tcc_pkg::CTRL_A_ADDR, 8'hFF);
        bus(1'b0, tcc_pkg::CTRL_A_ADDR, 8'h00);
        chk(16'(q), 16'h00F3);
        bus(1'b0, 8'h71, 8'h00);
        chk(16'(q), 16'h0000);
        clk_en = 1'b0;
        bus(1'b1, tcc_pkg::CTRL_A_ADDR, 8'h00);
        clk_en = 1'b1;
        bus(1'b0, tcc_pkg::CTRL_A_ADDR, 8'h00);
        chk(16'(q), 16'h00F3);
        // high byte once, then two low writes reuse it
        for (int k = 0; k < 4; k++)
        begin
            hi = 8'($urandom);
            bus(1'b1, 8'(8'h75 + 2 * k), hi);
            for (int j = 1; j >= 0; j--)
            begin
                r = (k + j) % 4;
                v = {hi, 8'($urandom)};
                bus(1'b1, 8'(8'h74 + 2 * r), v[7:0]);
                chk(wcap.data, v);
                chk(16'({wcap.valid, wcap.sel}), 16'({1'b1, 2'(r)}));
                ex[r] = v;
            end
        end
        @(negedge sys_clk);
        chk(16'(wr16.valid), 16'h0000);
        bus(1'b0, 8'h74, 8'h00);
        chk(16'(q), 16'(cs[7:0]));
        hc = cs[15:8];
        for (int k = 1; k < 3; k++)
        begin
            bus(1'b0, 8'(8'h74 + 2 * k), 8'h00);
            chk(16'(q), 16'(ex[k][7:0]));
            bus(1'b0, 8'(8'h75 + 2 * k), 8'h00);
            chk(16'(q), 16'(ex[k][15:8]));
        end
        repeat (300) @(negedge sys_clk);
        bus(1'b0, 8'h75, 8'h00);
        chk(16'(q), 16'(hc));
        bus(1'b0, 8'h7A, 8'h00);
        chk(16'(q), 16'(ex[3][7:0]));
        bus(1'b0, 8'h75, 8'h00);
        chk(16'(q), 16'(ex[3][15:8]));
        $display("test registers done");
        // channel a modes 3,2,1,0 in turn so a toggle starts from a known level
        for (int b = 0; b < 64; b++)
        begin
            // let the last drive of the previous pass reach an edge
            @(negedge sys_clk);
            clk_en = 1'b1;
            cmp_match = 2'b00;
            at_bottom = 1'b0;
            wg = b[5:2];
            md[0] = 2'(3 - b[1:0]);
            md[1] = 2'($urandom);
            wmh = wg[3:2];
            port_out = 2'($urandom);
            bus(1'b1, tcc_pkg::CTRL_A_ADDR,
                {md[0], md[1], 2'($urandom), wg[1:0]});
            repeat (3) @(negedge sys_clk);
            oe_exp = port_dir;
            for (int ch = 0; ch < 2; ch++)
                cn[ch] = conn(ch, md[ch], wg);
            repeat (24)
            begin
                @(negedge sys_clk);
                for (int ch = 0; ch < 2; ch++)
                begin
                    if (e[ch] >= 0)
                        chk(16'(compare_out[ch]), 16'(e[ch]));
                    chk(16'(out_connected[ch]), 16'(cn[ch]));
                    if (!cn[ch])
                        chk(16'(pin_out[ch]), 16'(port_out[ch]));
                    else if (e[ch] >= 0 && e[ch] == last[ch])
                        chk(16'(pin_out[ch]), 16'(e[ch]));
                    last[ch] = e[ch];
                end
                chk(16'(pin_oe), 16'(oe_exp));
                clk_en = ($urandom % 8) != 0;
                cmp_match = 2'($urandom) & 2'($urandom);
                at_bottom = ($urandom % 4) == 0;
                cmp_eq_top = 2'($urandom);
                count_up = 1'($urandom);
                port_dir = 2'($urandom);
                if (clk_en)
                begin
                    oe_exp = port_dir;
                    for (int ch = 0; ch < 2; ch++)
                        e[ch] = step(e[ch], ch, md[ch], wg, cmp_match[ch],
                                     cmp_eq_top[ch], at_bottom, count_up);
                end
            end
        end
        $display("test outputs done");
        final_report();
    end
endmodule : test_timer16_compare_output_control

`default_nettype wire
